// *** design/pin_edge_detect.v ***
// One pin's wake-up edge detector with selectable sensitivity.
// Assumes the pin level is already synchronised to the clock.
`timescale 1ns/100ps
`default_nettype none
`include "pin_wake_defs.vh"

module pin_edge_detect (
  input  wire       REF_CLK_I,
  input  wire       rst_i,
  input  wire       pin_i,
  input  wire [1:0] sel_i,
  output wire       wake_o
);

  reg  prev_ff;
  wire rise = pin_i & ~prev_ff;
  wire fall = ~pin_i & prev_ff;

  always @(posedge REF_CLK_I) begin
    if (rst_i) begin
      // Reset takes the pin level, so a pin idling high shows no false edge
      prev_ff <= pin_i;
    end else begin
      prev_ff <= pin_i;
    end
  end

  assign wake_o = ((sel_i == `EDGE_RISE) & rise) |
                  ((sel_i == `EDGE_FALL) & fall) |
                  ((sel_i == `EDGE_ANY) & (rise | fall));

endmodule
`default_nettype wire

// *** design/pin_wake_config_low.v ***
// Serially accessed wake-up configuration register for pins 0 to 2.
// Assumes SPI mode 0 clock and frames arriving as pins, sampled here
// on REF_CLK_I, well slower than the sampling clock.
//
// Contract
// - Every answer carries eight global flags in 15..8 and the register in 7..0.
// - Bits 7..6 set pin 0 wake-up: none, rising, falling or either edge.
// - Bits 5..4 set pin 1 wake-up with the same encodings.
// - Bits 3..2 set pin 2 wake-up with the same encodings.
// - Bit 1 inhibits the pin 1 interrupt pulse and its share of the pin summary flag.
// - Bit 0 inhibits the pin 0 interrupt pulse and its share of the pin summary flag.
// - Only power-on reset returns the fields to their defaults.
`timescale 1ns/100ps
`default_nettype none
`include "pin_wake_defs.vh"

module pin_wake_config_low (
  input  wire       REF_CLK_I,
  input  wire       SYS_RST_I,
  input  wire       POR_I,
  input  wire       SCLK_I,
  input  wire       CS_N_I,
  input  wire       MOSI_I,
  output wire       MISO_O,
  output wire       MISO_OE_N_O,
  input  wire [7:0] GLOBAL_FLAGS_I,
  input  wire [2:0] PIN_I,
  output reg  [2:0] WAKE_O,
  output reg  [1:0] INT_PULSE_O,
  output reg  [1:0] SUMMARY_CONTRIB_O,
  output wire [7:0] CFG_O
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg  [2:0] sclk_s1_ff;
  reg  [2:0] sclk_s2_ff;
  reg  [2:0] pin_s1_ff;
  reg  [2:0] pin_s2_ff;
  reg        sclk_prev_ff;
  wire       sclk_s = sclk_s2_ff[0];
  wire       cs_n_s = sclk_s2_ff[1];
  wire       mosi_s = sclk_s2_ff[2];

  // No reset here: two edges flush any old level on their own
  always @(posedge REF_CLK_I) begin
    sclk_s1_ff   <= {MOSI_I, CS_N_I, SCLK_I};
    sclk_s2_ff   <= sclk_s1_ff;
    pin_s1_ff    <= PIN_I;
    pin_s2_ff    <= pin_s1_ff;
    sclk_prev_ff <= sclk_s;
  end

  wire sclk_rise = sclk_s & ~sclk_prev_ff;
  wire sclk_fall = ~sclk_s & sclk_prev_ff;

  // ----------------------------------------------------------------
  // Frame shifter
  // ----------------------------------------------------------------
  // Frame states: waiting for select, taking bits, sixteen bits taken
  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_SHIFT = 2'b01;
  localparam [1:0] ST_FULL  = 2'b10;

  reg  [`FRAME_W-1:0] rx_ff;
  reg  [`FRAME_W-1:0] tx_ff;
  reg  [`CNT_W-1:0]   cnt_ff;
  reg  [7:0]          cfg_ff;
  reg  [1:0]          state_ff;
  reg  [1:0]          nxt_state;
  reg  [`FRAME_W-1:0] nxt_rx;
  reg                 frame_done;

  wire [`FRAME_W-1:0] answer_word = {GLOBAL_FLAGS_I, cfg_ff};
  // Bits count from the moment select is seen low; once sixteen are in,
  // extra bits are ignored and cannot wrap the counter to a false end
  wire                taking      = ~cs_n_s & (state_ff != ST_FULL);

  always @* begin
    nxt_rx     = {rx_ff[`FRAME_W-2:0], mosi_s};
    frame_done = sclk_rise & taking & ~SYS_RST_I & (cnt_ff == `CNT_LAST);
  end

  always @(posedge REF_CLK_I) begin
    if (SYS_RST_I | cs_n_s) begin
      cnt_ff <= `CNT_ZERO;
      rx_ff  <= {`FRAME_W{1'b0}};
      // Answer is loaded while select is high so bit 15 is ready at once
      tx_ff  <= answer_word;
    end else begin
      if (sclk_rise & taking) begin
        rx_ff  <= nxt_rx;
        cnt_ff <= cnt_ff + `CNT_ONE;
      end
      if (sclk_fall) begin
        tx_ff <= {tx_ff[`FRAME_W-2:0], 1'b0};
      end
    end
  end

  assign MISO_O      = tx_ff[`FRAME_W-1];
  assign MISO_OE_N_O = cs_n_s;

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  // Select seen high always returns to idle, whatever the state
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (~cs_n_s) begin
          nxt_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (cs_n_s) begin
          nxt_state = ST_IDLE;
        end else if (frame_done) begin
          nxt_state = ST_FULL;
        end
      end
      ST_FULL: begin
        if (cs_n_s) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Register write
  // ----------------------------------------------------------------
  // Odd parity over the whole frame; a bad frame leaves the fields alone
  wire parity_ok = ^nxt_rx;
  wire wr_hit    = (nxt_rx[`ADDR_MSB:`ADDR_LSB] == `CMD_WRITE_CODE);
  // A read frame, or any other code, only returns the answer word
  wire wr_take   = frame_done & wr_hit & parity_ok;

  always @(posedge REF_CLK_I) begin
    if (POR_I) begin
      cfg_ff <= `CFG_RESET;
    end else if (wr_take) begin
      cfg_ff <= nxt_rx[`DATA_MSB:0];
    end
  end

  assign CFG_O = cfg_ff;

  // ----------------------------------------------------------------
  // Wake-up detection and masking
  // ----------------------------------------------------------------
  wire [2:0] wake_raw;

  pin_edge_detect u_pin0 (
    .REF_CLK_I (REF_CLK_I),
    .rst_i     (SYS_RST_I),
    .pin_i     (pin_s2_ff[0]),
    .sel_i     (cfg_ff[`PIN0_SEL_MSB:`PIN0_SEL_LSB]),
    .wake_o    (wake_raw[0])
  );
  pin_edge_detect u_pin1 (
    .REF_CLK_I (REF_CLK_I),
    .rst_i     (SYS_RST_I),
    .pin_i     (pin_s2_ff[1]),
    .sel_i     (cfg_ff[`PIN1_SEL_MSB:`PIN1_SEL_LSB]),
    .wake_o    (wake_raw[1])
  );
  pin_edge_detect u_pin2 (
    .REF_CLK_I (REF_CLK_I),
    .rst_i     (SYS_RST_I),
    .pin_i     (pin_s2_ff[2]),
    .sel_i     (cfg_ff[`PIN2_SEL_MSB:`PIN2_SEL_LSB]),
    .wake_o    (wake_raw[2])
  );

  // ----------------------------------------------------------------
  // Inhibit masks and outputs
  // ----------------------------------------------------------------
  // Pin 2 has no inhibit bit, so it reaches only the raw wake output;
  // the mask acts on the pulse and the summary share alike
  wire pass_pin0 = ~cfg_ff[`PIN0_INH_BIT];
  wire pass_pin1 = ~cfg_ff[`PIN1_INH_BIT];

  always @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      WAKE_O            <= 3'h0;
      INT_PULSE_O       <= 2'h0;
      SUMMARY_CONTRIB_O <= 2'h0;
    end else begin
      WAKE_O <= wake_raw;
      INT_PULSE_O[0]       <= wake_raw[0] & pass_pin0;
      SUMMARY_CONTRIB_O[0] <= wake_raw[0] & pass_pin0;
      INT_PULSE_O[1]       <= wake_raw[1] & pass_pin1;
      SUMMARY_CONTRIB_O[1] <= wake_raw[1] & pass_pin1;
    end
  end

endmodule
`default_nettype wire

// *** design/pin_wake_defs.vh ***
// Constants for the pin wake-up configuration register block.
// Assumes inclusion by bare name from design files only.
`ifndef PIN_WAKE_DEFS_VH
`define PIN_WAKE_DEFS_VH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define FRAME_W          16
`define ADDR_MSB         15
`define ADDR_LSB         9
`define PARITY_BIT       8
`define DATA_MSB         7
`define CNT_W            5
`define CNT_LAST         5'h0f
`define CNT_ZERO         5'h00
`define CNT_ONE          5'h01
`define CMD_WRITE_CODE   7'h44
`define CMD_READ_CODE    7'h04

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PIN0_SEL_MSB     7
`define PIN0_SEL_LSB     6
`define PIN1_SEL_MSB     5
`define PIN1_SEL_LSB     4
`define PIN2_SEL_MSB     3
`define PIN2_SEL_LSB     2
`define PIN1_INH_BIT     1
`define PIN0_INH_BIT     0
`define CFG_RESET        8'h00

// ----------------------------------------------------------------
// Edge selection encodings
// ----------------------------------------------------------------
`define EDGE_NONE        2'h0
`define EDGE_RISE        2'h1
`define EDGE_FALL        2'h2
`define EDGE_ANY         2'h3

`endif

// *** verif/host_spi.sv ***
// Host model: SPI master, mode 0, MSB first.
// Assumes the block's clock as its time base.
`timescale 1ns/100ps
`default_nettype none
module host_spi (
  input  wire logic clk_i,
  input  wire logic miso_i,
  output var  logic sclk_o,
  output var  logic cs_n_o,
  output var  logic mosi_o
);
  initial {sclk_o, cs_n_o, mosi_o} = 3'h2;
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    cs_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_o <= tx[i];
      repeat (6) @(posedge clk_i);
      sclk_o <= 1'b1;
      rx[i] = miso_i;
      repeat (6) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    // Idle line inverted so no stale bit passes
    mosi_o <= ~tx[0];
    cs_n_o <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** verif/pin_wake_config_low_props.sv ***
// Port checker for the pin wake-up register.
// Assumes a bind to the block's top module.
`timescale 1ns/100ps
`default_nettype none
module pin_wake_config_low_props (
  input wire logic       REF_CLK_I,
  input wire logic       SYS_RST_I,
  input wire logic       POR_I,
  input wire logic       CS_N_I,
  input wire logic       MISO_OE_N_O,
  input wire logic [2:0] WAKE_O,
  input wire logic [1:0] INT_PULSE_O,
  input wire logic [7:0] CFG_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // Eight quiet cycles: any write has landed
  sequence quiet8; (CS_N_I && !POR_I) [*8]; endsequence
  sequence sel4; !CS_N_I [*4]; endsequence
  // Outputs are registered from the fields as they stood one cycle earlier
  a_wake_pin0: assert property (WAKE_O[0] |-> $past(CFG_O[7:6]) != 2'h0) else $error("wake0");
  a_wake_pin1: assert property (WAKE_O[1] |-> $past(CFG_O[5:4]) != 2'h0) else $error("wake1");
  a_wake_pin2: assert property (WAKE_O[2] |-> $past(CFG_O[3:2]) != 2'h0) else $error("wake2");
  a_int_inh_pin0: assert property (INT_PULSE_O[0] == (WAKE_O[0] && !$past(CFG_O[0])))
    else $error("int0");
  a_int_inh_pin1: assert property (INT_PULSE_O[1] == (WAKE_O[1] && !$past(CFG_O[1])))
    else $error("int1");
  a_por_clears: assert property (POR_I |=> CFG_O == 8'h00) else $error("por");
  a_rst_keeps: assert property (disable iff (POR_I) SYS_RST_I |=> $stable(CFG_O))
    else $error("rst");
  a_idle_stable: assert property (quiet8 |-> $stable(CFG_O)) else $error("idle");
  a_oe_select: assert property (sel4 |-> !MISO_OE_N_O) else $error("oe");
endmodule
`default_nettype wire

// *** verif/tb_pin_wake_config_low.sv ***
// Bench: host frames and pin edges.
// Assumes host model and checker compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_pin_wake_config_low;
  logic clk = 0, rst = 1, por = 1, sclk, cs_n, mosi, miso, oe_n;
  logic [7:0] flg = 8'ha5, cfg, exp_cfg = 8'h00;
  logic [2:0] pin = 3'h0, wk;
  logic [1:0] ip, sc;
  logic [15:0] rx;
  int err_total = 0, checks = 0;
  initial forever #12.5 clk = ~clk;
  pin_wake_config_low u_pin_wake_config_low (.REF_CLK_I(clk), .SYS_RST_I(rst), .POR_I(por),
    .SCLK_I(sclk), .CS_N_I(cs_n), .MOSI_I(mosi), .MISO_O(miso), .MISO_OE_N_O(oe_n),
    .GLOBAL_FLAGS_I(flg), .PIN_I(pin), .WAKE_O(wk), .INT_PULSE_O(ip),
    .SUMMARY_CONTRIB_O(sc), .CFG_O(cfg));
  host_spi u_host_spi (.clk_i(clk), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
  task automatic chk(input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic pc(input logic [7:0] c, input logic [2:0] p, w, input logic [1:0] i);
    logic [6:0] m;
    m = 7'h0;
    u_host_spi.xfer({7'h44, ~^c, c}, rx);
    chk(rx[15:8], flg);
    chk(rx[7:0], exp_cfg);
    chk(cfg, c);
    exp_cfg = c;
    pin <= p;
    // Pulses are looked at mid-cycle, away from the edge that launches them
    repeat (12) begin
      @(negedge clk);
      m = m | {wk, ip, sc};
    end
    @(posedge clk);
    chk(m, {w, i, i});
  endtask
  task automatic t_first();
    u_host_spi.xfer(16'h0800, rx);
    chk(rx, {flg, 8'h00});
    chk(oe_n, 1'b1);
    $display("first");
  endtask
  task automatic t_edges();
    pc(8'h6c, 3'h7, 3'h5, 2'h1);
    pc(8'h6c, 3'h0, 3'h6, 2'h2);
    pc(8'h03, 3'h7, 3'h0, 2'h0);
    $display("edges");
  endtask
  task automatic t_inh();
    pc(8'hf3, 3'h0, 3'h3, 2'h0);
    pc(8'hfc, 3'h7, 3'h7, 2'h3);
    pc(8'hf1, 3'h0, 3'h3, 2'h2);
    $display("inhibit");
  endtask
  task automatic t_frame();
    flg <= 8'h5a;
    u_host_spi.xfer({7'h44, ^8'h81, 8'h81}, rx);
    u_host_spi.xfer(16'h08ff, rx);
    u_host_spi.xfer(16'h0800, rx);
    chk(rx, {8'h5a, 8'hf1});
    $display("frame");
  endtask
  task automatic t_resets();
    logic [2:0] m;
    m = 3'h0;
    // Pins held high across a reset must not read as a fresh edge
    pin <= 3'h7;
    repeat (6) @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    repeat (8) begin
      @(negedge clk);
      m = m | wk;
    end
    @(posedge clk);
    chk(m, 3'h0);
    chk(cfg, 8'hf1);
    por <= 1;
    @(posedge clk);
    por <= 0;
    repeat (4) @(posedge clk);
    chk(cfg, 8'h00);
    $display("resets");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    {rst, por} <= 2'h0;
    repeat (4) @(posedge clk);
    t_first();
    t_edges();
    t_inh();
    t_frame();
    t_resets();
    results();
  end
endmodule
bind pin_wake_config_low pin_wake_config_low_props u_props (.REF_CLK_I(REF_CLK_I),
  .SYS_RST_I(SYS_RST_I), .POR_I(POR_I), .CS_N_I(CS_N_I), .MISO_OE_N_O(MISO_OE_N_O),
  .WAKE_O(WAKE_O), .INT_PULSE_O(INT_PULSE_O), .CFG_O(CFG_O));
`default_nettype wire
